// file: bench/ext_wait_state_gen_tb_top.sv
// Testbench for the external bus wait-state generator
`timescale 1ns/1ps
`default_nettype none
module ext_wait_state_gen_tb_top;
	import wait_state_pkg::*;
	logic        core_clk = 0, rst = 1, req = 0, write = 0, off_chip = 0, adc_done = 0;
	logic        ready, done, addr_oe, data_oe, strobe_n, prog_sel_n, data_sel_n, io_sel_n;
	logic        write_n;
	logic [1:0]  space = 2'h0;
	logic [3:0]  delay = 4'h0;
	logic [15:0] addr = 16'h0000, wdata = 16'h0000, prog_addr = 16'h1234;
	logic [15:0] data_in, rdata, addr_out, data_out, sel;
	int          num_errors = 0, total_checks = 0, n, exp_n;

	always #12.5 core_clk = ~core_clk;

	ext_wait_state_gen i_ext_wait_state_gen (.CORE_CLK(core_clk), .RST(rst), .REQ(req),
		.SPACE(space), .WRITE(write), .OFF_CHIP(off_chip), .ADDR(addr), .WDATA(wdata),
		.PROG_ADDR(prog_addr), .READY(ready), .ADC_DONE(adc_done), .DATA_IN(data_in),
		.DONE(done), .RDATA(rdata), .ADDR_OUT(addr_out), .ADDR_OE(addr_oe),
		.DATA_OUT(data_out), .DATA_OE(data_oe), .EXTERNAL_ACCESS_STROBE_N(strobe_n),
		.PROGRAM_SPACE_SELECT_N(prog_sel_n), .DATA_SPACE_SELECT_N(data_sel_n),
		.IO_SPACE_SELECT_N(io_sel_n), .WRITE_N(write_n));
	slow_ext_memory i_slow_ext_memory (.clk(core_clk), .rst(rst), .strobe_n(strobe_n),
		.delay(delay), .addr(addr_out), .ready(ready), .data(data_in));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Called at a falling edge; request held until DONE is seen
	task automatic access(input logic [1:0] sp, input logic wr, input logic oc,
		input logic [15:0] a, input logic [15:0] wd);
		n = 0;
		space = sp;
		write = wr;
		off_chip = oc;
		addr = a;
		wdata = wd;
		req = 1'b1;
		while (n < 40)
		begin
			@(posedge core_clk);
			n++;
			@(negedge core_clk);
			if (n == 1)
				sel = {10'h000, strobe_n, prog_sel_n, data_sel_n, io_sel_n, write_n, data_oe};
			if (done === 1'b1)
				break;
		end
		check("access done", 16'h0001, {15'h0, done});
		req = 1'b0;
		// Let one edge pass so a following call never raises req in this time step
		@(negedge core_clk);
	endtask

	task automatic reg_rd(input string what, input logic [15:0] exp);
		access(SPACE_IO, 1'b0, 1'b0, WAIT_STATE_CONTROL_ADDR, 16'h0000);
		check(what, exp, rdata);
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#500us;
		num_errors++;
		stop_test();
	end

	initial
	begin
		repeat (20) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		reg_rd("ctrl reset", {12'h000, CTRL_RESET});
		check("trace oe", 16'h0001, {15'h0, addr_oe});
		check("trace addr", prog_addr, addr_out);
		access(SPACE_IO, 1'b1, 1'b0, WAIT_STATE_CONTROL_ADDR, 16'hfff0);
		reg_rd("ctrl cleared", 16'h0000);
		check("trace off oe", 16'h0000, {15'h0, addr_oe});
		// Same address in data space goes off chip and must not touch the register
		access(SPACE_DATA, 1'b1, 1'b1, 16'hffff, 16'h000f);
		check("data write cycles", 16'd3, 16'(n));
		reg_rd("ctrl untouched", 16'h0000);
		adc_done = 1'b1;
		@(negedge core_clk);
		adc_done = 1'b0;
		reg_rd("ctrl adc set", 16'h0001);
		for (int g = 0; g < 2; g++)
			for (int d = 0; d < 4; d += 3)
				for (int s = 0; s < 3; s++)
				begin
					// With g set, only the wait bit of the space under test is set, so a swapped bit shows
					access(SPACE_IO, 1'b1, 1'b0, WAIT_STATE_CONTROL_ADDR,
						g ? (16'h0008 | (16'h0001 << s)) : 16'h0008);
					delay = 4'(d);
					exp_n = 2 + ((g > d) ? g : d);
					access(2'(s), 1'b0, 1'b1, 16'h8000 | 16'(s), 16'h0000);
					check("read cycles", 16'(exp_n), 16'(n));
					check("read data", (16'h8000 | 16'(s)) ^ 16'ha5a5, rdata);
					check("read sel", {10'h0, 1'b0, s != 0, s != 1, s != 2, 2'b10}, sel);
					access(2'(s), 1'b1, 1'b1, 16'h4000 | 16'(s), 16'h5aa5);
					check("write cycles", 16'd3, 16'(n));
					check("write data", 16'h5aa5, data_out);
					check("write sel", {10'h0, 1'b0, s != 0, s != 1, s != 2, 2'b01}, sel);
				end
		access(SPACE_DATA, 1'b0, 1'b0, 16'h0200, 16'h0000);
		check("on-chip cycles", 16'd1, 16'(n));
		check("on-chip sel", 16'h003e, sel);
		stop_test();
	end
endmodule // ext_wait_state_gen_tb_top
`default_nettype wire

// file: bench/slow_ext_memory.sv
// Slow external memory model with a programmable ready delay
`timescale 1ns/1ps
`default_nettype none
module slow_ext_memory
(
	input  wire logic        clk,      // Machine clock
	input  wire logic        rst,      // Async reset, high
	input  wire logic        strobe_n, // Off-chip access strobe
	input  wire logic [3:0]  delay,    // Ready-low cycles per access
	input  wire logic [15:0] addr,     // External address bus
	output logic             ready,    // Ready back to the device
	output logic      [15:0] data      // Read data bus
);
	logic [3:0]  cnt_q;
	logic [15:0] last_q;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q  <= 4'h0;
			last_q <= 16'h0000;
		end
		else
		begin
			cnt_q  <= strobe_n ? 4'h0 : cnt_q + 4'h1;
			last_q <= data;
		end
	end
	// Pulled up when not selected, so nothing unrelated is stalled
	assign ready = strobe_n | (cnt_q >= delay);
	// A released bus toggles every cycle so a stale value never matches
	assign data = strobe_n ? ~last_q : (addr ^ 16'ha5a5);
endmodule // slow_ext_memory
`default_nettype wire

// file: shared/wait_state_pkg.sv
// Constants and types shared by the external bus wait-state generator
`default_nettype none
package wait_state_pkg;
	localparam logic [15:0] WAIT_STATE_CONTROL_ADDR = 16'hffff; // I/O-space location
	localparam int          PROG_WAIT_BIT          = 0;
	localparam int          DATA_WAIT_BIT          = 1;
	localparam int          IO_WAIT_BIT            = 2;
	localparam int          TRACE_BIT              = 3;
	localparam int          CTRL_BITS              = 4;
	localparam logic [3:0]  CTRL_RESET             = 4'hf;
	localparam logic [11:0] RESERVED_READ          = 12'h000;
	localparam logic [1:0]  WRITE_CYCLES           = 2'h2;
	localparam logic [1:0]  SPACE_PROG             = 2'h0;
	localparam logic [1:0]  SPACE_DATA             = 2'h1;
	localparam logic [1:0]  SPACE_IO               = 2'h2;

	typedef enum logic [3:0]
	{
		ST_IDLE = 4'h1,
		ST_GEN  = 4'h2,
		ST_RDY  = 4'h4,
		ST_WR   = 4'h8
	} bus_state_t;
endpackage
`default_nettype wire

// file: verilog/ext_wait_state_gen.sv
// External bus wait-state generator: access sequencing, strobes and control register
// Operation
// - Wait states begin and end only on machine-clock cycle boundaries.
// - Ready low on a read: wait one cycle, resample; never complete a read until ready high.
// - Ready is honoured from a read's first bus cycle unless a wait state is generated.
// - Enabled space gets its first wait state regardless of ready.
// - Control register sits at I/O address top, reached by I/O accesses.
// - Upper twelve control register bits always read zero.
// - Trace bit drives program address onto idle bus; never waits.
// - I/O wait bit adds one wait state to off-chip I/O reads.
// - Data wait bit adds one wait state to off-chip data reads.
// - Program wait bit adds one wait state to off-chip program reads.
// - Conversion done sets the program wait bit.
// - Every external write takes exactly two machine cycles.
// - Reset sets all four control bits to one.
// - Ready may stretch an access after the generated wait state.
// - Off-chip I/O-space access drives the I/O select low.
// - Strobe low during off-chip access; strobe and selects high otherwise.
`timescale 1ns/1ps
`default_nettype none
module ext_wait_state_gen
	import wait_state_pkg::*;
(
	input  wire logic        CORE_CLK,                 // Machine clock, 40 MHz
	input  wire logic        RST,                      // Async reset, high
	input  wire logic        REQ,                      // Core access request
	input  wire logic [1:0]  SPACE,                    // Address space of request
	input  wire logic        WRITE,                    // 1 = write access
	input  wire logic        OFF_CHIP,                 // Access maps off chip
	input  wire logic [15:0] ADDR,                     // Access address
	input  wire logic [15:0] WDATA,                    // Write data
	input  wire logic [15:0] PROG_ADDR,                // Internal program address
	input  wire logic        READY,                    // External ready, high = done
	input  wire logic        ADC_DONE,                 // Conversion finished pulse
	input  wire logic [15:0] DATA_IN,                  // External data bus input
	output logic             DONE,                     // Access complete, one cycle
	output logic      [15:0] RDATA,                    // Read data
	output logic      [15:0] ADDR_OUT,                 // External address bus
	output logic             ADDR_OE,                  // Address bus drive enable
	output logic      [15:0] DATA_OUT,                 // External data bus output
	output logic             DATA_OE,                  // Data bus drive enable
	output logic             EXTERNAL_ACCESS_STROBE_N, // Off-chip access strobe
	output logic             PROGRAM_SPACE_SELECT_N,   // Program space select
	output logic             DATA_SPACE_SELECT_N,      // Data space select
	output logic             IO_SPACE_SELECT_N,        // I/O space select
	output logic             WRITE_N                   // Write strobe
);
	////////////////////////////////////////////////////////////////////////////
	bus_state_t           state_q, state_d;
	logic [1:0]           space_q, space_d;
	logic [15:0]          addr_q, addr_d;
	logic [15:0]          wdata_q, wdata_d;
	logic [15:0]          rdata_q, rdata_d;
	logic                 done_q, done_d;
	logic                 wr_cnt_q, wr_cnt_d;
	logic [CTRL_BITS-1:0] ctrl;
	logic [15:0]          ctrl_rd;
	logic                 reg_hit, reg_wr, gen_wait;

	// Control register is an on-chip I/O location, so it never drives the bus
	assign reg_hit = REQ && state_q == ST_IDLE && SPACE == SPACE_IO
		&& ADDR == WAIT_STATE_CONTROL_ADDR;
	assign reg_wr  = reg_hit && WRITE;

	wait_control_reg i_wait_control_reg
	(
		.clk      (CORE_CLK),
		.rst      (RST),
		.wr_en    (reg_wr),
		.wr_data  (WDATA),
		.adc_done (ADC_DONE),
		.rd_data  (ctrl_rd),
		.ctrl     (ctrl)
	);

	always_comb
	begin
		unique case (SPACE)
			SPACE_PROG: gen_wait = ctrl[PROG_WAIT_BIT];
			SPACE_DATA: gen_wait = ctrl[DATA_WAIT_BIT];
			default:    gen_wait = ctrl[IO_WAIT_BIT];
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		state_d  = state_q;
		space_d  = space_q;
		addr_d   = addr_q;
		wdata_d  = wdata_q;
		rdata_d  = rdata_q;
		done_d   = 1'b0;
		wr_cnt_d = wr_cnt_q;
		unique case (state_q)
			ST_IDLE:
			begin
				if (reg_hit)
				begin
					done_d = 1'b1;
					if (!WRITE)
						rdata_d = ctrl_rd;
				end
				else if (REQ && OFF_CHIP)
				begin
					space_d = SPACE;
					addr_d  = ADDR;
					wdata_d = WDATA;
					if (WRITE)
					begin
						wr_cnt_d = 1'b0;
						state_d  = ST_WR;
					end
					else if (gen_wait)
						state_d = ST_GEN;
					else
						state_d = ST_RDY;
				end
				else if (REQ)
					done_d = 1'b1;
			end
			// Generated wait state ignores ready entirely
			ST_GEN:
				state_d = ST_RDY;
			ST_RDY:
			begin
				// Ready resampled each cycle until high
				if (READY)
				begin
					rdata_d = DATA_IN;
					done_d  = 1'b1;
					state_d = ST_IDLE;
				end
			end
			ST_WR:
			begin
				// Fixed length keeps driver turnaround safe; ready is not consulted
				wr_cnt_d = 1'b1;
				if (wr_cnt_q)
				begin
					done_d  = 1'b1;
					state_d = ST_IDLE;
				end
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
		begin
			state_q  <= ST_IDLE;
			space_q  <= SPACE_PROG;
			addr_q   <= 16'h0000;
			wdata_q  <= 16'h0000;
			rdata_q  <= 16'h0000;
			done_q   <= 1'b0;
			wr_cnt_q <= 1'b0;
		end
		else
		begin
			state_q  <= state_d;
			space_q  <= space_d;
			addr_q   <= addr_d;
			wdata_q  <= wdata_d;
			rdata_q  <= rdata_d;
			done_q   <= done_d;
			wr_cnt_q <= wr_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	logic active;
	assign active = state_q != ST_IDLE;

	assign DONE                     = done_q;
	assign RDATA                    = rdata_q;
	assign EXTERNAL_ACCESS_STROBE_N = !active;
	assign PROGRAM_SPACE_SELECT_N   = !(active && space_q == SPACE_PROG);
	assign DATA_SPACE_SELECT_N      = !(active && space_q == SPACE_DATA);
	assign IO_SPACE_SELECT_N        = !(active && space_q == SPACE_IO);
	assign WRITE_N                  = !(state_q == ST_WR);
	assign DATA_OUT                 = wdata_q;
	assign DATA_OE                  = state_q == ST_WR;
	// Trace mode exposes the fetch address on an idle bus; off saves power and noise
	assign ADDR_OUT                 = active ? addr_q : PROG_ADDR;
	assign ADDR_OE                  = active || ctrl[TRACE_BIT];

	////////////////////////////////////////////////////////////////////////////
	sequence s_read_start;
		state_q == ST_IDLE && REQ && OFF_CHIP && !WRITE && !reg_hit;
	endsequence

	chk_gen_wait_len: assert property (@(posedge CORE_CLK) disable iff (RST)
		s_read_start and gen_wait |=> state_q == ST_GEN ##1 state_q == ST_RDY)
		else $error("generated wait not one cycle");
	chk_no_gen_wait: assert property (@(posedge CORE_CLK) disable iff (RST)
		s_read_start and !gen_wait |=> state_q == ST_RDY)
		else $error("unexpected generated wait");
	chk_ready_low_holds: assert property (@(posedge CORE_CLK) disable iff (RST)
		state_q == ST_RDY && !READY |=> state_q == ST_RDY && !done_q)
		else $error("completed with ready low");
	chk_ready_high_done: assert property (@(posedge CORE_CLK) disable iff (RST)
		state_q == ST_RDY && READY |=> done_q && state_q == ST_IDLE)
		else $error("ready high not honoured");
	chk_write_two_cyc: assert property (@(posedge CORE_CLK) disable iff (RST)
		$rose(state_q == ST_WR) |-> (state_q == ST_WR) [*2] ##1 state_q == ST_IDLE)
		else $error("write not two cycles");
	chk_strobe_idle: assert property (@(posedge CORE_CLK) disable iff (RST)
		state_q == ST_IDLE |-> EXTERNAL_ACCESS_STROBE_N && IO_SPACE_SELECT_N
		&& PROGRAM_SPACE_SELECT_N && DATA_SPACE_SELECT_N)
		else $error("strobe active while idle");
	chk_io_select: assert property (@(posedge CORE_CLK) disable iff (RST)
		s_read_start and SPACE == SPACE_IO |=> !IO_SPACE_SELECT_N && DATA_SPACE_SELECT_N)
		else $error("I/O select wrong");
	chk_trace_drive: assert property (@(posedge CORE_CLK) disable iff (RST)
		!active |-> ADDR_OE == ctrl[TRACE_BIT])
		else $error("trace drive wrong");
	chk_reg_read: assert property (@(posedge CORE_CLK) disable iff (RST)
		reg_hit && !WRITE |=> done_q && RDATA == $past(ctrl_rd))
		else $error("register read wrong");
endmodule // ext_wait_state_gen
`default_nettype wire

// file: verilog/wait_control_reg.sv
// Wait-state control register with reserved bits and conversion-done set
`timescale 1ns/1ps
`default_nettype none
module wait_control_reg
	import wait_state_pkg::*;
(
	input  wire logic                 clk,        // Machine clock
	input  wire logic                 rst,        // Async reset, high
	input  wire logic                 wr_en,      // Register write strobe
	input  wire logic [15:0]          wr_data,    // Write data
	input  wire logic                 adc_done,   // Conversion finished pulse
	output logic      [15:0]          rd_data,    // Read view
	output logic      [CTRL_BITS-1:0] ctrl        // Stored control bits
);
	logic [CTRL_BITS-1:0] ctrl_q;
	logic [CTRL_BITS-1:0] ctrl_d;

	always_comb
	begin
		ctrl_d = ctrl_q;
		if (wr_en)
			ctrl_d = wr_data[CTRL_BITS-1:0];
		// Set wins over a same-cycle software clear
		if (adc_done)
			ctrl_d[PROG_WAIT_BIT] = 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ctrl_q <= CTRL_RESET;
		else
			ctrl_q <= ctrl_d;
	end

	assign ctrl    = ctrl_q;
	assign rd_data = {RESERVED_READ, ctrl_q};

	chk_adc_sets_prog: assert property (@(posedge clk) disable iff (rst)
		adc_done |=> ctrl_q[PROG_WAIT_BIT]) else $error("conversion did not set wait bit");
	chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
		rd_data[15:CTRL_BITS] == RESERVED_READ) else $error("reserved bits not zero");
endmodule // wait_control_reg
`default_nettype wire
